// File: design/sept_consts.svh
`ifndef SEPT_CONSTS_SVH
`define SEPT_CONSTS_SVH
`define A_CFG 10'h000
`define A_CTRL_L 10'h004
`define A_CTRL_H 10'h008
`define A_COUNT 10'h00C
`define A_STATE 10'h010
`define A_OUT 10'h014
`define A_FLAG 10'h018
`define A_IRQEN 10'h01C
`define A_DMAEN 10'h020
`define A_CAPMODE 10'h024
`define A_MATCH 10'h040
`define A_MATCH_END 10'h068
`define A_EV 10'h080
`define A_EV_END 10'h120
`define N_EV 10
`define N_MR 10
`define N_OUT 8
`define N_IN 8
`define N_ST 10
`define CFG_UNIFY 0
`define CFG_CLKSEL 1
`define CFG_CLKIN 2
`define CFG_ALIM_L 5
`define CFG_ALIM_H 6
`define CT_STOP 0
`define CT_HALT 1
`define CT_BIDIR 2
`define CT_DIR 3
`define CTRL_RST 4'h2
`define EC_MIDX 0
`define EC_HI 4
`define EC_IOC 5
`define EC_IOIDX 8
`define EC_IOOUT 11
`define EC_COMB 12
`define EC_DIRQ 14
`define EC_DIRDN 15
`define EC_HOLD 16
`define EC_STLD 17
`define EC_NXST 18
`define EC_START 22
`define EC_STOP 23
`define EC_HALT 24
`define EC_LIMIT 25
`define ST_H 16
`endif

// File: design/sept_pkg.sv
package sept_pkg;
    typedef enum logic [2:0] {
        IO_NONE = 3'h0,
        IO_RISE = 3'h1,
        IO_FALL = 3'h2,
        IO_HIGH = 3'h3,
        IO_LOW = 3'h4
    } io_cond_e;
    typedef enum logic [1:0] {
        COMB_OR = 2'h0,
        COMB_MATCH = 2'h1,
        COMB_IO = 2'h2,
        COMB_AND = 2'h3
    } comb_e;
    typedef logic [3:0] state_t;
    typedef logic [9:0] reg_addr_t;
endpackage

// File: design/mc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mc_if;
    logic wr_en;
    logic [3:0] wr_idx;
    logic [31:0] wr_data;
    logic [9:0] cap_lo;
    logic [9:0] cap_hi;
    logic [31:0] cnt;
    logic [9:0][31:0] value;
    modport ctl (output wr_en, wr_idx, wr_data, cap_lo, cap_hi, cnt, input value);
    modport mem (input wr_en, wr_idx, wr_data, cap_lo, cap_hi, cnt, output value);
endinterface
`default_nettype wire

// File: design/match_cap_mem.sv
`timescale 1ns/1ps
`default_nettype none
`include "sept_consts.svh"
module match_cap_mem (
    input wire logic clock,
    input wire logic rst_n,
    mc_if.mem mc
);
    logic [9:0][31:0] val_ff;

    assign mc.value = val_ff;

    // Capture beats a software write in the same cycle; halves captured independently
    for (genvar i = 0; i < `N_MR; i++)
    begin : g_mr
        logic wr_hit;
        assign wr_hit = mc.wr_en && (mc.wr_idx == 4'(i));
        always_ff @(posedge clock or negedge rst_n)
        begin
            if (!rst_n)
                val_ff[i] <= 32'h0000_0000;
            else
            begin
                if (mc.cap_lo[i])
                    val_ff[i][15:0] <= mc.cnt[15:0];
                else if (wr_hit)
                    val_ff[i][15:0] <= mc.wr_data[15:0];
                if (mc.cap_hi[i])
                    val_ff[i][31:16] <= mc.cnt[31:16];
                else if (wr_hit)
                    val_ff[i][31:16] <= mc.wr_data[31:16];
            end
        end
    end
endmodule
`default_nettype wire

// File: design/state_event_pwm_timer.sv
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sept_consts.svh"
module state_event_pwm_timer (
    input wire logic clock,
    input wire logic rst_n,
    input wire sept_pkg::reg_addr_t reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [7:0] in_pin,
    output logic [7:0] out_pin,
    output logic irq,
    output logic dma_req
);
    import sept_pkg::*;

    mc_if mc ();

    match_cap_mem u_mem (
        .clock(clock),
        .rst_n(rst_n),
        .mc(mc)
    );

    logic [6:0] cfg_ff;
    logic [1:0][3:0] ctrl_ff;
    logic [31:0] cnt_ff;
    logic [1:0] dir_ff;
    state_t [1:0] st_ff;
    logic [7:0] out_ff;
    logic [7:0] out_prev_ff;
    logic [9:0] flag_ff;
    logic [9:0] irqen_ff;
    logic [9:0] dmaen_ff;
    logic [9:0] capmode_ff;
    logic [9:0] hold_ff;
    logic [9:0][9:0] ev_st_ff;
    logic [9:0][25:0] ev_ctl_ff;
    logic [9:0][23:0] ev_out_ff;
    logic [9:0][9:0] ev_cap_ff;
    logic [7:0] in_meta_ff;
    logic [7:0] in_sync_ff;
    logic [7:0] in_prev_ff;
    logic [31:0] rdata_ff;
    logic irq_ff;
    logic dma_ff;

    logic [31:0] nxt_cnt;
    logic [1:0] nxt_dir;
    logic [1:0][3:0] nxt_ctrl;
    state_t [1:0] nxt_st;
    logic [7:0] nxt_out;
    logic [9:0] nxt_flag;
    logic [9:0] nxt_hold;
    logic [31:0] nxt_rdata;

    // Register decode
    wire unify = cfg_ff[`CFG_UNIFY];
    wire [2:0] clkin = cfg_ff[`CFG_CLKIN +: 3];
    wire in_mr = (reg_addr >= `A_MATCH) && (reg_addr < `A_MATCH_END);
    wire in_ev = (reg_addr >= `A_EV) && (reg_addr < `A_EV_END);
    wire [9:0] mr_off = reg_addr - `A_MATCH;
    wire [9:0] ev_off = reg_addr - `A_EV;
    wire [3:0] mr_idx = mr_off[5:2];
    wire [3:0] ev_idx = ev_off[7:4];
    wire [1:0] ev_sub = reg_addr[3:2];
    wire wr_cfg = reg_wr && (reg_addr == `A_CFG);
    wire wr_count = reg_wr && (reg_addr == `A_COUNT);
    wire wr_state = reg_wr && (reg_addr == `A_STATE);
    wire wr_out = reg_wr && (reg_addr == `A_OUT);
    wire wr_flag = reg_wr && (reg_addr == `A_FLAG);
    wire [1:0] wr_ctrl = {reg_wr && (reg_addr == `A_CTRL_H), reg_wr && (reg_addr == `A_CTRL_L)};

    assign mc.wr_en = reg_wr && in_mr;
    assign mc.wr_idx = mr_idx;
    assign mc.wr_data = reg_wdata;
    assign mc.cnt = cnt_ff;

    // Count enable: every cycle, or rising edge of the selected synchronised input
    wire tick = cfg_ff[`CFG_CLKSEL] ? (in_sync_ff[clkin] && !in_prev_ff[clkin]) : 1'b1;

    // Match compare per register, per half and on the full word
    logic [9:0] eq_lo;
    logic [9:0] eq_hi;
    for (genvar i = 0; i < `N_MR; i++)
    begin : g_cmp
        wire full = cnt_ff == mc.value[i];
        assign eq_lo[i] = unify ? full : (cnt_ff[15:0] == mc.value[i][15:0]);
        assign eq_hi[i] = !unify && (cnt_ff[31:16] == mc.value[i][31:16]);
    end

    wire [1:0] run = {!ctrl_ff[1][`CT_STOP] && !ctrl_ff[1][`CT_HALT] && !unify,
        !ctrl_ff[0][`CT_STOP] && !ctrl_ff[0][`CT_HALT]};

    // Event qualification
    logic [9:0] fired;
    logic [9:0] ev_half;
    logic [9:0] mq_now;
    for (genvar e = 0; e < `N_EV; e++)
    begin : g_ev
        wire [25:0] c = ev_ctl_ff[e];
        wire h = c[`EC_HI] && !unify;
        wire [3:0] mi = c[`EC_MIDX +: 4];
        wire [2:0] ii = c[`EC_IOIDX +: 3];
        wire io_cur = c[`EC_IOOUT] ? out_ff[ii] : in_sync_ff[ii];
        wire io_prv = c[`EC_IOOUT] ? out_prev_ff[ii] : in_prev_ff[ii];
        wire m_raw = (mi < 4'(`N_MR)) && (h ? eq_hi[mi] : eq_lo[mi]) && tick && run[h];
        wire m_q = m_raw || (c[`EC_HOLD] && hold_ff[e]);
        logic io_q;
        always_comb
        begin
            unique case (io_cond_e'(c[`EC_IOC +: 3]))
                IO_RISE: io_q = io_cur && !io_prv;
                IO_FALL: io_q = !io_cur && io_prv;
                IO_HIGH: io_q = io_cur;
                IO_LOW: io_q = !io_cur;
                default: io_q = 1'b0;
            endcase
        end
        logic cond;
        always_comb
        begin
            unique case (comb_e'(c[`EC_COMB +: 2]))
                COMB_OR: cond = m_q || io_q;
                COMB_MATCH: cond = m_q;
                COMB_IO: cond = io_q;
                COMB_AND: cond = m_q && io_q;
            endcase
        end
        wire st_ok = (st_ff[h] < 4'(`N_ST)) && ev_st_ff[e][st_ff[h]];
        wire dir_ok = !c[`EC_DIRQ] || !ctrl_ff[h][`CT_BIDIR] ||
            (dir_ff[h] == c[`EC_DIRDN]);
        assign fired[e] = st_ok && dir_ok && cond;
        assign ev_half[e] = h;
        assign mq_now[e] = m_raw;
    end

    // Gather per-half counter actions, captures and output actions
    logic [1:0] act_start;
    logic [1:0] act_stop;
    logic [1:0] act_halt;
    logic [1:0] act_lim;
    logic [1:0] st_ld;
    state_t [1:0] st_new;
    logic [7:0] o_set;
    logic [7:0] o_clr;
    logic [7:0] o_tgl;
    logic [9:0] cap_lo;
    logic [9:0] cap_hi;
    always_comb
    begin
        act_start = 2'h0;
        act_stop = 2'h0;
        act_halt = 2'h0;
        act_lim = 2'h0;
        st_ld = 2'h0;
        st_new = st_ff;
        o_set = 8'h00;
        o_clr = 8'h00;
        o_tgl = 8'h00;
        cap_lo = 10'h000;
        cap_hi = 10'h000;
        for (int e = `N_EV - 1; e >= 0; e--)
        begin
            if (fired[e])
            begin
                act_start[ev_half[e]] = act_start[ev_half[e]] | ev_ctl_ff[e][`EC_START];
                act_stop[ev_half[e]] = act_stop[ev_half[e]] | ev_ctl_ff[e][`EC_STOP];
                act_halt[ev_half[e]] = act_halt[ev_half[e]] | ev_ctl_ff[e][`EC_HALT];
                act_lim[ev_half[e]] = act_lim[ev_half[e]] | ev_ctl_ff[e][`EC_LIMIT];
                if (ev_ctl_ff[e][`EC_STLD])
                begin
                    st_ld[ev_half[e]] = 1'b1;
                    st_new[ev_half[e]] = ev_ctl_ff[e][`EC_NXST +: 4];
                end
                o_set = o_set | ev_out_ff[e][7:0];
                o_clr = o_clr | ev_out_ff[e][15:8];
                o_tgl = o_tgl | ev_out_ff[e][23:16];
                if (ev_half[e] || unify)
                    cap_hi = cap_hi | (ev_cap_ff[e] & capmode_ff);
                if (!ev_half[e])
                    cap_lo = cap_lo | (ev_cap_ff[e] & capmode_ff);
            end
        end
    end
    assign mc.cap_lo = cap_lo;
    assign mc.cap_hi = cap_hi;

    // Match 0 as automatic limit on each half
    wire [1:0] lim = act_lim | {cfg_ff[`CFG_ALIM_H] && eq_hi[0],
        cfg_ff[`CFG_ALIM_L] && eq_lo[0]};

    function automatic logic [32:0] step(input logic [31:0] v, input logic dn,
        input logic bidir, input logic l);
        logic [31:0] r;
        logic d;
        r = v + 32'h0000_0001;
        d = 1'b0;
        if (!bidir)
            r = l ? 32'h0000_0000 : v + 32'h0000_0001;
        else if (!dn && l)
        begin
            d = 1'b1;
            r = v - 32'h0000_0001;
        end
        else if (dn && v == 32'h0000_0000)
            r = v + 32'h0000_0001;
        else
        begin
            d = dn;
            r = dn ? v - 32'h0000_0001 : v + 32'h0000_0001;
        end
        return {d, r};
    endfunction

    logic [32:0] s_lo;
    logic [32:0] s_hi;
    always_comb
    begin
        s_lo = step(unify ? cnt_ff : {16'h0000, cnt_ff[15:0]}, dir_ff[0],
            ctrl_ff[0][`CT_BIDIR], lim[0]);
        s_hi = step({16'h0000, cnt_ff[31:16]}, dir_ff[1], ctrl_ff[1][`CT_BIDIR], lim[1]);
        nxt_cnt = cnt_ff;
        nxt_dir = dir_ff;
        if (wr_count)
            nxt_cnt = reg_wdata;
        else if (unify)
        begin
            if (run[0] && tick)
                {nxt_dir[0], nxt_cnt} = s_lo;
        end
        else
        begin
            if (run[0] && tick)
                {nxt_dir[0], nxt_cnt[15:0]} = {s_lo[32], s_lo[15:0]};
            if (run[1] && tick)
                {nxt_dir[1], nxt_cnt[31:16]} = {s_hi[32], s_hi[15:0]};
        end
    end

    // Control: event set beats software clear in the same cycle
    always_comb
    begin
        for (int h = 0; h < 2; h++)
        begin
            nxt_ctrl[h] = ctrl_ff[h];
            if (wr_ctrl[h])
                nxt_ctrl[h][2:0] = reg_wdata[2:0];
            if (act_start[h])
                nxt_ctrl[h][`CT_STOP] = 1'b0;
            if (act_stop[h])
                nxt_ctrl[h][`CT_STOP] = 1'b1;
            if (act_halt[h])
                nxt_ctrl[h][`CT_HALT] = 1'b1;
            nxt_ctrl[h][`CT_DIR] = nxt_dir[h];
            nxt_st[h] = st_ld[h] ? st_new[h] :
                (wr_state ? reg_wdata[h * `ST_H +: 4] : st_ff[h]);
        end
    end

    // Outputs: set or clear alone beats toggle; toggle alone flips; set plus clear flips
    for (genvar o = 0; o < `N_OUT; o++)
    begin : g_out
        wire sc = o_set[o] && o_clr[o];
        assign nxt_out[o] = (sc || (o_tgl[o] && !o_set[o] && !o_clr[o])) ? !out_ff[o] :
            o_clr[o] ? 1'b0 : o_set[o] ? 1'b1 : wr_out ? reg_wdata[o] : out_ff[o];
    end

    assign nxt_flag = fired | (flag_ff & ~(wr_flag ? reg_wdata[9:0] : 10'h000));
    assign nxt_hold = ~fired & (hold_ff | mq_now);

    always_comb
    begin
        nxt_rdata = 32'h0000_0000;
        if (in_mr)
            nxt_rdata = mc.value[mr_idx];
        else if (in_ev)
        begin
            unique case (ev_sub)
                2'h0: nxt_rdata = {22'h00_0000, ev_st_ff[ev_idx]};
                2'h1: nxt_rdata = {6'h00, ev_ctl_ff[ev_idx]};
                2'h2: nxt_rdata = {8'h00, ev_out_ff[ev_idx]};
                2'h3: nxt_rdata = {22'h00_0000, ev_cap_ff[ev_idx]};
            endcase
        end
        else
        begin
            unique case (reg_addr)
                `A_CFG: nxt_rdata = {25'h000_0000, cfg_ff};
                `A_CTRL_L: nxt_rdata = {28'h000_0000, ctrl_ff[0]};
                `A_CTRL_H: nxt_rdata = {28'h000_0000, ctrl_ff[1]};
                `A_COUNT: nxt_rdata = cnt_ff;
                `A_STATE: nxt_rdata = {12'h000, st_ff[1], 12'h000, st_ff[0]};
                `A_OUT: nxt_rdata = {24'h00_0000, out_ff};
                `A_FLAG: nxt_rdata = {22'h00_0000, flag_ff};
                `A_IRQEN: nxt_rdata = {22'h00_0000, irqen_ff};
                `A_DMAEN: nxt_rdata = {22'h00_0000, dmaen_ff};
                `A_CAPMODE: nxt_rdata = {22'h00_0000, capmode_ff};
                default: nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            in_meta_ff <= 8'h00;
            in_sync_ff <= 8'h00;
            in_prev_ff <= 8'h00;
            out_prev_ff <= 8'h00;
        end
        else
        begin
            in_meta_ff <= in_pin;
            in_sync_ff <= in_meta_ff;
            in_prev_ff <= in_sync_ff;
            out_prev_ff <= out_ff;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_ff <= 32'h0000_0000;
            dir_ff <= 2'h0;
            ctrl_ff <= {`CTRL_RST, `CTRL_RST};
            st_ff <= 8'h00;
            out_ff <= 8'h00;
            flag_ff <= 10'h000;
            hold_ff <= 10'h000;
            rdata_ff <= 32'h0000_0000;
            irq_ff <= 1'b0;
            dma_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            dir_ff <= nxt_dir;
            ctrl_ff <= nxt_ctrl;
            st_ff <= nxt_st;
            out_ff <= nxt_out;
            flag_ff <= nxt_flag;
            hold_ff <= nxt_hold;
            rdata_ff <= reg_rd ? nxt_rdata : 32'h0000_0000;
            irq_ff <= |(nxt_flag & irqen_ff);
            dma_ff <= |(fired & dmaen_ff);
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_ff <= 7'h00;
            irqen_ff <= 10'h000;
            dmaen_ff <= 10'h000;
            capmode_ff <= 10'h000;
            ev_st_ff <= '0;
            ev_ctl_ff <= '0;
            ev_out_ff <= '0;
            ev_cap_ff <= '0;
        end
        else if (reg_wr)
        begin
            if (wr_cfg)
                cfg_ff <= reg_wdata[6:0];
            if (reg_addr == `A_IRQEN)
                irqen_ff <= reg_wdata[9:0];
            if (reg_addr == `A_DMAEN)
                dmaen_ff <= reg_wdata[9:0];
            if (reg_addr == `A_CAPMODE)
                capmode_ff <= reg_wdata[9:0];
            if (in_ev && ev_sub == 2'h0)
                ev_st_ff[ev_idx] <= reg_wdata[9:0];
            if (in_ev && ev_sub == 2'h1)
                ev_ctl_ff[ev_idx] <= reg_wdata[25:0];
            if (in_ev && ev_sub == 2'h2)
                ev_out_ff[ev_idx] <= reg_wdata[23:0];
            if (in_ev && ev_sub == 2'h3)
                ev_cap_ff[ev_idx] <= reg_wdata[9:0];
        end
    end

    assign reg_rdata = rdata_ff;
    assign out_pin = out_ff;
    assign irq = irq_ff;
    assign dma_req = dma_ff;
endmodule
`default_nettype wire

// File: sim/sept_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "sept_consts.svh"
module sept_chk (
    input wire sept_pkg::reg_addr_t reg_addr,
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [7:0] in_pin,
    input wire logic [7:0] out_pin,
    input wire logic irq,
    input wire logic dma_req
);
    import sept_pkg::*;
    logic ev_armed_ff;
    logic irq_en_ff;
    logic dma_en_ff;
    wire logic ev_mask_wr;
    wire logic hole_rd;
    // Any event with a nonzero state mask may act on its own from here on
    assign ev_mask_wr = reg_wr && reg_addr >= `A_EV && reg_addr < `A_EV_END
        && reg_addr[3:0] == 4'h0 && reg_wdata[9:0] != 10'h000;
    assign hole_rd = reg_rd && (reg_addr >= `A_EV_END
        || (reg_addr > `A_CAPMODE && reg_addr < `A_MATCH));
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ev_armed_ff <= 1'b0;
            irq_en_ff <= 1'b0;
            dma_en_ff <= 1'b0;
        end
        else
        begin
            ev_armed_ff <= ev_armed_ff | ev_mask_wr;
            if (reg_wr && reg_addr == `A_IRQEN)
                irq_en_ff <= |reg_wdata[9:0];
            if (reg_wr && reg_addr == `A_DMAEN)
                dma_en_ff <= |reg_wdata[9:0];
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_read_window: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
        else $error("read data outside its cycle");
    a_out_readback: assert property (reg_rd && reg_addr == `A_OUT
        |=> reg_rdata == {24'h00_0000, $past(out_pin)}) else $error("output readback wrong");
    a_hole_zero: assert property (hole_rd |=> reg_rdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_flag_width: assert property (reg_rd && reg_addr == `A_FLAG
        |=> reg_rdata[31:10] == 22'h00_0000) else $error("flag upper bits set");
    a_ctrl_width: assert property (reg_rd && reg_addr == `A_CTRL_L
        |=> reg_rdata[31:4] == 28'h000_0000) else $error("control upper bits set");
    a_quiet_out: assert property (!ev_armed_ff && $changed(out_pin)
        |-> $past(reg_wr) && $past(reg_addr) == `A_OUT) else $error("output moved unasked");
    a_quiet_dma: assert property (!ev_armed_ff |-> !dma_req)
        else $error("dma with no event armed");
    a_irq_gate: assert property (!irq_en_ff && !$past(irq_en_ff) |-> !irq)
        else $error("interrupt while disabled");
    a_dma_gate: assert property (!dma_en_ff && !$past(dma_en_ff) |-> !dma_req)
        else $error("dma while disabled");
endmodule
bind state_event_pwm_timer sept_chk i_chk (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_pin(in_pin),
    .out_pin(out_pin), .irq(irq), .dma_req(dma_req)
);
`default_nettype wire

// File: sim/pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module pin_model (
    input wire logic clock,
    input wire logic [7:0] out_pin,
    output logic [7:0] in_pin
);
    int rises = 0;
    logic [7:0] out_last_ff = 8'h00;
    initial in_pin = 8'h00;
    // Counts rising edges on output 0 as an external load would see them
    always @(posedge clock)
    begin
        if (out_pin[0] === 1'b1 && out_last_ff[0] !== 1'b1)
            rises++;
        out_last_ff <= out_pin;
    end
    // Inputs move just after an edge and then hold as a level
    task automatic drive(input int idx, input logic val);
        @(posedge clock);
        in_pin[idx] <= val;
    endtask
endmodule
`default_nettype wire

// File: sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sept_consts.svh"
module tb_top;
    import sept_pkg::*;
    logic clock;
    logic rst_n;
    reg_addr_t reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic [7:0] in_pin;
    logic [7:0] out_pin;
    logic irq;
    logic dma_req;
    int bad_count = 0;
    int check_count = 0;
    int cycles = 0;
    int hi;
    int lo;
    logic dm;
    state_event_pwm_timer i_dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .in_pin(in_pin), .out_pin(out_pin), .irq(irq), .dma_req(dma_req));
    pin_model i_pins (.clock(clock), .out_pin(out_pin), .in_pin(in_pin));
    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            bad_count++;
            results();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // Waits for a rise on output b, then measures its high and low time in cycles
    task automatic pulse(input int b, output int h, output int l, output logic d);
        h = 0;
        l = 0;
        cyc(1);
        while (out_pin[b] !== 1'b1 && h < 40)
        begin
            cyc(1);
            h++;
        end
        d = dma_req;
        h = 0;
        while (out_pin[b] === 1'b1 && h < 20)
        begin
            cyc(1);
            h++;
        end
        while (out_pin[b] === 1'b0 && l < 20)
        begin
            cyc(1);
            l++;
        end
    endtask
    task automatic wr(input reg_addr_t a, input logic [31:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input reg_addr_t a, input logic [31:0] e);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, e);
    endtask
    task automatic ev(input logic [3:0] e, input logic [31:0] m, input logic [31:0] c,
            input logic [31:0] act);
        wr(`A_EV + {2'b00, e, 4'h0}, m);
        wr(`A_EV + {2'b00, e, 4'h4}, c);
        wr(`A_EV + {2'b00, e, 4'h8}, act);
    endtask
    initial
    begin
        rst_n = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        rd(`A_CTRL_L, 32'h0000_0002);
        rd(`A_COUNT, 32'h0000_0000);
        rd(`A_STATE, 32'h0000_0000);
        rd(10'h028, 32'h0000_0000);
        wr(`A_OUT, 32'h0000_005A);
        rd(`A_OUT, 32'h0000_005A);
        wr(`A_OUT, 32'h0000_0000);
        $display("reset and register test done");
        wr(`A_MATCH, 32'h0000_0009);
        wr(`A_MATCH + 10'h004, 32'h0000_0003);
        wr(`A_CFG, 32'h0000_0020);
        ev(4'h0, 32'h0000_0001, 32'h0000_1000, 32'h0000_0001);
        ev(4'h1, 32'h0000_0001, 32'h0000_1001, 32'h0000_0100);
        wr(`A_DMAEN, 32'h0000_0001);
        wr(`A_IRQEN, 32'h0000_0001);
        wr(`A_CTRL_L, 32'h0000_0000);
        pulse(0, hi, lo, dm);
        check({31'h0, dm}, 32'h0000_0001);
        check(hi, 4);
        check(lo, 6);
        check(i_pins.rises, 1);
        check({31'h0, irq}, 32'h0000_0001);
        rd(`A_FLAG, 32'h0000_0003);
        $display("pwm test done");
        wr(`A_CTRL_L, 32'h0000_0002);
        wr(`A_FLAG, 32'h0000_03FF);
        rd(`A_FLAG, 32'h0000_0000);
        cyc(2);
        check({31'h0, irq}, 32'h0000_0000);
        wr(`A_COUNT, 32'h0000_0005);
        cyc(4);
        rd(`A_COUNT, 32'h0000_0005);
        $display("halt test done");
        wr(`A_OUT, 32'h0000_0000);
        wr(`A_STATE, 32'h0000_0000);
        wr(`A_COUNT, 32'h0000_0000);
        ev(4'h0, 32'h0000_0001, 32'h0006_1000, 32'h0000_0001);
        wr(`A_CTRL_L, 32'h0000_0000);
        cyc(30);
        rd(`A_STATE, 32'h0000_0001);
        check({31'h0, out_pin[0]}, 32'h0000_0001);
        $display("state test done");
        for (int c = 1; c <= 2; c++)
        begin
            ev(4'h2, 32'h0000_03FF, 32'h0000_220F | (c << 5), 32'h0080_0000);
            wr(`A_OUT, 32'h0000_0000);
            i_pins.drive(2, 1'b1);
            cyc(6);
            check({31'h0, out_pin[7]}, (c == 1) ? 32'h1 : 32'h0);
            i_pins.drive(2, 1'b0);
            cyc(6);
            check({31'h0, out_pin[7]}, 32'h0000_0001);
        end
        $display("input edge test done");
        wr(`A_CTRL_L, 32'h0000_0002);
        wr(`A_STATE, 32'h0000_0002);
        wr(`A_CFG, 32'h0000_0001);
        wr(`A_COUNT, 32'h0000_FFFE);
        wr(`A_MATCH + 10'h004, 32'h0001_0003);
        wr(`A_CAPMODE, 32'h0000_0004);
        ev(4'h3, 32'h0000_03FF, 32'h0080_1001, 32'h0000_0000);
        wr(`A_EV + 10'h03C, 32'h0000_0004);
        ev(4'h4, 32'h0000_03FF, 32'h0040_236F, 32'h0000_0000);
        wr(`A_CTRL_L, 32'h0000_0000);
        cyc(20);
        rd(`A_COUNT, 32'h0001_0004);
        rd(`A_MATCH + 10'h008, 32'h0001_0003);
        rd(`A_CTRL_L, 32'h0000_0001);
        i_pins.drive(3, 1'b1);
        cyc(6);
        wr(`A_CTRL_L, 32'h0000_0002);
        rd(`A_COUNT, 32'h0001_0009);
        $display("unified capture test done");
        wr(`A_CFG, 32'h0000_0040);
        wr(`A_COUNT, 32'h0000_0000);
        wr(`A_MATCH, 32'h0004_0000);
        wr(`A_MATCH + 10'h00C, 32'h0002_0000);
        ev(4'h5, 32'h0000_03FF, 32'h0000_D013, 32'h0000_0040);
        ev(4'h6, 32'h0000_03FF, 32'h0000_5013, 32'h0000_4000);
        wr(`A_CTRL_H, 32'h0000_0004);
        pulse(6, hi, lo, dm);
        check(hi, 4);
        check(lo, 4);
        $display("up down test done");
        results();
    end
endmodule
`default_nettype wire
